// ---- dac_channel_update_control.sv ----
`timescale 1ns/1ps
`include "dac_channel_consts.svh"

module dac_channel_update_control
    import dac_channel_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic por_resetn_i,
    input wire sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    input wire trig_in_t trig_i,
    output logic [`CODE_WIDTH-1:0] code_o,
    output logic drive_en_o,
    output logic [1:0] gain_o
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic en_reg;
    logic persist_reg;
    logic left_reg;
    trigger_sel_t trig_reg;
    logic [1:0] gain_reg;
    logic [7:0] low_reg;
    logic [7:0] high_reg;
    logic inhibit_reg;
    logic [`CODE_WIDTH-1:0] code_reg;
    logic [3:0] cell_prev_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic clear_all;
    logic hold;
    logic wr_cfg_a;
    logic wr_cfg_b;
    logic wr_low;
    logic wr_high;
    logic fire;
    logic update;
    logic [3:0] cell_rise;
    logic [`CODE_WIDTH-1:0] assembled;

    // ---------------------------------------------------------------
    // Reset and write decode
    // ---------------------------------------------------------------
    // Power-on always clears; other resets clear only in normal mode.
    assign clear_all = !por_resetn_i || (!resetn_i && !persist_reg); // RQ2 RQ3
    // A persisting channel freezes while a soft reset is asserted.
    assign hold = !resetn_i; // RQ3
    assign wr_cfg_a = sfr_req_i.wr && sfr_req_i.addr == `CH_CFG_A_ADDR;
    assign wr_cfg_b = sfr_req_i.wr && sfr_req_i.addr == `CH_CFG_B_ADDR;
    assign wr_low = sfr_req_i.wr && sfr_req_i.addr == `CH_DATA_LOW_ADDR;
    assign wr_high = sfr_req_i.wr && sfr_req_i.addr == `CH_DATA_HIGH_ADDR;

    // Configuration A; reserved bits are not stored and read as zero.
    always_ff @(posedge ref_clk_i) begin
        if (clear_all) begin
            en_reg <= 1'(`CFG_A_RESET >> `CFG_ENABLE_BIT); // RQ1
            persist_reg <= 1'b0; // RQ2
            left_reg <= 1'b0; // RQ4
            trig_reg <= every_cycle_trigger; // RQ6
        end else if (!hold && wr_cfg_a) begin
            en_reg <= sfr_req_i.wdata[`CFG_ENABLE_BIT]; // RQ1
            persist_reg <= sfr_req_i.wdata[`CFG_PERSIST_BIT];
            left_reg <= sfr_req_i.wdata[`CFG_LEFT_BIT]; // RQ4
            trig_reg <= trigger_sel_t'(sfr_req_i.wdata[`CFG_TRIG_MSB:0]);
        end
    end

    // Configuration B holds the output buffer gain only.
    always_ff @(posedge ref_clk_i) begin
        if (clear_all) begin
            gain_reg <= `GAIN_RESET; // RQ13
        end else if (!hold && wr_cfg_b) begin
            gain_reg <= sfr_req_i.wdata[`GAIN_MSB:0]; // RQ13
        end
    end

    // Data bytes; software is expected to write low before high.
    always_ff @(posedge ref_clk_i) begin
        if (clear_all) begin
            low_reg <= `DATA_RESET; // RQ15
            high_reg <= `DATA_RESET; // RQ16
        end else if (!hold) begin
            if (wr_low) begin
                low_reg <= sfr_req_i.wdata; // RQ15 RQ11
            end
            if (wr_high) begin
                high_reg <= sfr_req_i.wdata; // RQ16
            end
        end
    end

    // A low write blocks updates until the matching high write lands.
    always_ff @(posedge ref_clk_i) begin
        if (clear_all) begin
            inhibit_reg <= 1'b0;
        end else if (!hold) begin
            if (wr_low) begin
                inhibit_reg <= 1'b1; // RQ9
            end else if (wr_high) begin
                inhibit_reg <= 1'b0; // RQ10
            end
        end
    end

    // ---------------------------------------------------------------
    // Trigger selection and code transfer
    // ---------------------------------------------------------------
    // Edge history is not part of the persisting state, so a soft reset
    // simply restarts it; a cell that is high at release counts as one rising edge.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || !por_resetn_i) begin
            cell_prev_reg <= 4'h0;
        end else begin
            cell_prev_reg <= trig_i.cell_out;
        end
    end

    assign cell_rise = trig_i.cell_out & ~cell_prev_reg; // RQ8

    // Right aligned uses the low twelve bits of the pair, left the high.
    assign assembled = left_reg ? {high_reg, low_reg[7:4]}
                                : {high_reg[3:0], low_reg}; // RQ5 RQ4

    always_comb begin
        unique case (trig_reg)
            every_cycle_trigger: fire = 1'b1; // RQ6
            timer_3_high_overflow: fire = trig_i.timer_ovf[0]; // RQ7
            timer_4_high_overflow: fire = trig_i.timer_ovf[1]; // RQ7
            timer_5_high_overflow: fire = trig_i.timer_ovf[2]; // RQ7
            logic_cell_out_0: fire = cell_rise[0]; // RQ8
            logic_cell_out_1: fire = cell_rise[1]; // RQ8
            logic_cell_out_2: fire = cell_rise[2]; // RQ8
            logic_cell_out_3: fire = cell_rise[3]; // RQ8
        endcase
    end

    assign update = fire && !inhibit_reg && !hold; // RQ9

    // The live code register is what reaches the converter.
    always_ff @(posedge ref_clk_i) begin
        if (clear_all) begin
            code_reg <= {`CODE_WIDTH{1'b0}}; // RQ2 RQ3
        end else if (update) begin
            code_reg <= assembled; // RQ6 RQ7 RQ8
        end
    end

    // ---------------------------------------------------------------
    // Register read path, one cycle latency, no side effects
    // ---------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        unique case (sfr_req_i.addr)
            `CH_CFG_A_ADDR: rdata_next = {en_reg, persist_reg, left_reg,
                                          2'h0, trig_reg};
            `CH_CFG_B_ADDR: rdata_next = {6'h00, gain_reg};
            `CH_DATA_LOW_ADDR: rdata_next = low_reg;
            `CH_DATA_HIGH_ADDR: rdata_next = high_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || !por_resetn_i) begin
            rdata_reg <= 8'h00;
        end else if (sfr_req_i.rd) begin
            rdata_reg <= rdata_next;
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign code_o = code_reg;
    assign drive_en_o = en_reg; // RQ1
    assign gain_o = gain_reg; // RQ13

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking

    sequence seq_low_write;
        resetn_i && por_resetn_i && wr_low;
    endsequence

    sequence seq_high_write;
        resetn_i && por_resetn_i && wr_high;
    endsequence

    chk_enable_drive: assert property ( // RQ1
        disable iff (!resetn_i || !por_resetn_i)
        wr_cfg_a |=> drive_en_o == $past(sfr_req_i.wdata[7]))
        else $error("Drive enable does not follow the written bit.");

    chk_normal_reset: assert property ( // RQ2
        por_resetn_i && !resetn_i && !persist_reg |=>
            !drive_en_o && code_o == 12'h000 && gain_o == 2'h1
            && low_reg == 8'h00 && high_reg == 8'h00)
        else $error("Normal reset left channel state behind.");

    chk_persist_hold: assert property ( // RQ3
        por_resetn_i && !resetn_i && persist_reg |=>
            $stable(code_o) && $stable(drive_en_o) && persist_reg)
        else $error("Persisting channel changed during soft reset.");

    chk_por_clear: assert property ( // RQ3
        !por_resetn_i |=> code_o == 12'h000 && !drive_en_o
            && !persist_reg && gain_o == 2'h1)
        else $error("Power-on reset did not clear the channel.");

    chk_code_align: assert property ( // RQ5
        disable iff (!resetn_i || !por_resetn_i)
        update |=> code_o == ($past(left_reg)
            ? {$past(high_reg), $past(low_reg[7:4])}
            : {$past(high_reg[3:0]), $past(low_reg)}))
        else $error("Converter code misaligned.");

    chk_every_cycle: assert property ( // RQ6
        disable iff (!resetn_i || !por_resetn_i)
        trig_reg == every_cycle_trigger && !inhibit_reg
            |=> code_o == $past(assembled))
        else $error("Every-cycle trigger did not transfer.");

    chk_timer_idle: assert property ( // RQ7
        disable iff (!resetn_i || !por_resetn_i)
        trig_reg == timer_4_high_overflow && !trig_i.timer_ovf[1]
            |=> $stable(code_o))
        else $error("Output moved without its timer overflow.");

    chk_cell_edge: assert property ( // RQ8
        disable iff (!resetn_i || !por_resetn_i)
        trig_reg == logic_cell_out_2 && !inhibit_reg
            && trig_i.cell_out[2] && !$past(trig_i.cell_out[2])
            |=> code_o == $past(assembled))
        else $error("Cell rising edge did not transfer.");

    chk_inhibit_hold: assert property ( // RQ9
        disable iff (!resetn_i || !por_resetn_i)
        inhibit_reg |=> $stable(code_o))
        else $error("Output changed while updates inhibited.");

    // A low write must arm the inhibit so a half word never transfers.
    chk_low_inhibit: assert property ( // RQ9
        disable iff (!resetn_i || !por_resetn_i)
        seq_low_write |=> inhibit_reg)
        else $error("Low write did not inhibit updates.");

    // Low and high decode to different addresses, so a high write alone
    // must always leave the inhibit released.
    chk_high_release: assert property ( // RQ10
        disable iff (!resetn_i || !por_resetn_i)
        seq_high_write |=> !inhibit_reg)
        else $error("High write did not release inhibit.");

    chk_low_readback: assert property ( // RQ15
        disable iff (!resetn_i || !por_resetn_i)
        sfr_req_i.rd && sfr_req_i.addr == `CH_DATA_LOW_ADDR
            |=> sfr_rdata_o == $past(low_reg))
        else $error("Low data readback wrong.");

endmodule : dac_channel_update_control

// ---- dac_channel_consts.svh ----
`ifndef DAC_CHANNEL_CONSTS_SVH
`define DAC_CHANNEL_CONSTS_SVH
// Summary of operation
// RQ1: Enable bit 7 resets to 0; 0 leaves pin undriven, 1 drives it.
// RQ2: With persist bit 6 clear, any reset restores all channel registers.
// RQ3: With persist bit set, only power-on reset clears output and settings.
// RQ4: Bit 5 resets to 0; 0 means right-justified, 1 left-justified input.
// RQ5: Code is built from both data bytes, aligned by the justify bit.
// RQ6: Trigger field bits 2:0 resets to 0; value 0 updates every cycle.
// RQ7: Values 1 to 3 update on timer three, four, five high overflow.
// RQ8: Values 4 to 7 update on rising edge of logic cells 0 to 3.
// RQ9: Trigger events while updates are inhibited leave the output unchanged.
// RQ10: Writing the high byte releases the inhibit set by a low write.
// RQ11: Software writes the low byte first and the high byte second.
// RQ12: Software writes reserved configuration bits with zero.
// RQ13: Buffer gain bits 1:0 reset to 1; full scale is reference times gain.
// RQ14: Software picks both gains so full scale is one times reference.
// RQ15: Low data register is 8-bit read-write, reset to zero.
// RQ16: High data register is 8-bit read-write, reset to zero.

// ---------------------------------------------------------------
// Register addresses in the special-function space
// ---------------------------------------------------------------
`define CH_DATA_LOW_ADDR 8'h89
`define CH_DATA_HIGH_ADDR 8'h8a
`define CH_CFG_A_ADDR 8'h93
`define CH_CFG_B_ADDR 8'h94

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CFG_ENABLE_BIT 7
`define CFG_PERSIST_BIT 6
`define CFG_LEFT_BIT 5
`define CFG_TRIG_MSB 2
`define GAIN_MSB 1
`define CFG_A_RESET 8'h00
`define GAIN_RESET 2'h1
`define DATA_RESET 8'h00
`define CODE_WIDTH 12
`endif

// ---- dac_channel_pkg.sv ----
package dac_channel_pkg;

    // Update trigger sources in field order.
    typedef enum logic [2:0] {
        every_cycle_trigger,
        timer_3_high_overflow,
        timer_4_high_overflow,
        timer_5_high_overflow,
        logic_cell_out_0,
        logic_cell_out_1,
        logic_cell_out_2,
        logic_cell_out_3
    } trigger_sel_t;

    // One access on the special-function register port.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_t;

    // Trigger event inputs from neighbouring logic on the same clock.
    typedef struct packed {
        logic [2:0] timer_ovf;
        logic [3:0] cell_out;
    } trig_in_t;

endpackage : dac_channel_pkg

// ---- dac_channel_update_control_bench.sv ----
`timescale 1ns/1ps
`include "dac_channel_consts.svh"

module dac_channel_update_control_bench
    import dac_channel_pkg::*;
    ;

    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic por_resetn_i = 1'b0;
    sfr_req_t req = '0;
    trig_in_t trig = '0;
    logic [7:0] rdata;
    logic [`CODE_WIDTH-1:0] code;
    logic drive_en;
    logic [1:0] gain;
    logic [`CODE_WIDTH-1:0] exp_code;
    logic [6:0] sel;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    // Free-running system clock of 40 ns.
    always #20 ref_clk_i = ~ref_clk_i;

    dac_channel_update_control dut (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .por_resetn_i(por_resetn_i),
        .sfr_req_i(req),
        .sfr_rdata_o(rdata),
        .trig_i(trig),
        .code_o(code),
        .drive_en_o(drive_en),
        .gain_o(gain)
    );

    // ---------------------------------------------------------------
    // Access and compare tasks
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk_port(input string what, input logic [11:0] exp,
                            input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_port

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp,
                           input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error reg %h expected %h seen %h", a, exp, got);
        end
    endtask : chk_reg

    // A write is a one-cycle strobe; a gap cycle always follows it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge ref_clk_i);
        req <= '0;
    endtask : wr

    // Read data is registered, so it is looked at half a cycle later.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge ref_clk_i);
        req <= '0;
        @(negedge ref_clk_i);
        chk_reg(a, exp, rdata);
    endtask : rd_chk

    // Pulses timers and cells together; a cell pulse is one rising edge.
    task automatic fire(input logic [6:0] src);
        @(posedge ref_clk_i);
        trig <= '{timer_ovf: src[2:0], cell_out: src[6:3]};
        @(posedge ref_clk_i);
        trig <= '0;
        repeat (2) @(negedge ref_clk_i);
    endtask : fire

    // A write attempted inside the reset must be dropped.
    task automatic do_reset(input bit por);
        @(posedge ref_clk_i);
        if (por) por_resetn_i <= 1'b0;
        else resetn_i <= 1'b0;
        wr(`CH_DATA_LOW_ADDR, 8'h99);
        @(posedge ref_clk_i);
        por_resetn_i <= 1'b1;
        resetn_i <= 1'b1;
        @(negedge ref_clk_i);
    endtask : do_reset

    task automatic chk_cleared();
        rd_chk(`CH_CFG_A_ADDR, 8'h00);
        rd_chk(`CH_CFG_B_ADDR, 8'h01);
        rd_chk(`CH_DATA_LOW_ADDR, 8'h00);
        rd_chk(`CH_DATA_HIGH_ADDR, 8'h00);
        chk_port("code", 12'h000, code);
        chk_port("drive", 12'h000, {11'h0, drive_en});
        chk_port("gain", 12'h001, {10'h0, gain});
    endtask : chk_cleared

    // Hang guard well above the few hundred cycles the run needs.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (8) @(posedge ref_clk_i);
        por_resetn_i <= 1'b1;
        resetn_i <= 1'b1;
        @(negedge ref_clk_i);
        chk_cleared();
        rd_chk(8'h90, 8'h00);
        $display("test reset_values done");
        // Reserved bits are written as ones on purpose and must read zero.
        wr(`CH_CFG_A_ADDR, 8'hff);
        rd_chk(`CH_CFG_A_ADDR, 8'he7);
        chk_port("drive", 12'h001, {11'h0, drive_en});
        wr(`CH_CFG_B_ADDR, 8'hff);
        rd_chk(`CH_CFG_B_ADDR, 8'h03);
        chk_port("gain", 12'h003, {10'h0, gain});
        $display("test config done");
        wr(`CH_CFG_A_ADDR, 8'h80);
        wr(`CH_DATA_LOW_ADDR, 8'h34);
        wr(`CH_DATA_HIGH_ADDR, 8'h02);
        repeat (2) @(negedge ref_clk_i);
        chk_port("code", 12'h234, code);
        wr(`CH_DATA_LOW_ADDR, 8'h56);
        repeat (3) @(negedge ref_clk_i);
        chk_port("code", 12'h234, code);
        rd_chk(`CH_DATA_LOW_ADDR, 8'h56);
        wr(`CH_DATA_HIGH_ADDR, 8'hfa);
        repeat (2) @(negedge ref_clk_i);
        chk_port("code", 12'ha56, code);
        rd_chk(`CH_DATA_HIGH_ADDR, 8'hfa);
        wr(`CH_CFG_A_ADDR, 8'ha0);
        wr(`CH_DATA_LOW_ADDR, 8'hbc);
        wr(`CH_DATA_HIGH_ADDR, 8'hde);
        repeat (2) @(negedge ref_clk_i);
        chk_port("code", 12'hdeb, code);
        $display("test justify done");
        // Each timer and cell source must fire alone; all other sources fire first.
        exp_code = 12'hdeb;
        for (int m = 1; m < 8; m++) begin
            sel = 7'h01 << (m - 1);
            wr(`CH_CFG_A_ADDR, 8'h80 | 8'(m));
            wr(`CH_DATA_LOW_ADDR, 8'(16 * m + 3));
            wr(`CH_DATA_HIGH_ADDR, 8'(m));
            fire(~sel);
            chk_port("code", exp_code, code);
            exp_code = {4'(m), 8'(16 * m + 3)};
            fire(sel);
            chk_port("code", exp_code, code);
        end
        $display("test triggers done");
        wr(`CH_CFG_A_ADDR, 8'hc1);
        wr(`CH_DATA_LOW_ADDR, 8'h77);
        wr(`CH_DATA_HIGH_ADDR, 8'h05);
        fire(7'h01);
        do_reset(1'b0);
        rd_chk(`CH_CFG_A_ADDR, 8'hc1);
        rd_chk(`CH_DATA_LOW_ADDR, 8'h77);
        chk_port("code", 12'h577, code);
        chk_port("drive", 12'h001, {11'h0, drive_en});
        chk_port("gain", 12'h003, {10'h0, gain});
        wr(`CH_CFG_A_ADDR, 8'h81);
        do_reset(1'b0);
        chk_cleared();
        wr(`CH_CFG_A_ADDR, 8'hc0);
        wr(`CH_CFG_B_ADDR, 8'h02);
        do_reset(1'b1);
        chk_cleared();
        $display("test resets done");
        test_done();
    end

endmodule : dac_channel_update_control_bench
